//--- include/plic_pkg.sv
// Constants, register map and carrier types of the program level interrupt control.
// Assumes a 16-bit processor that drives the register port from its privileged operations.
package plic_pkg;

    // ************************************************************
    // Sizes.
    // ************************************************************
    localparam int DATA_W   = 16;
    localparam int LEVELS   = 16;
    localparam int ADDR_W   = 8;
    localparam int LEVEL_W  = 4;
    localparam int CAUSE_W  = 4;

    // ************************************************************
    // Register map.
    // ************************************************************
    localparam logic [7:0] ADDR_REQUEST      = 8'h00;
    localparam logic [7:0] ADDR_ENABLE       = 8'h01;
    localparam logic [7:0] ADDR_SOURCE_EN    = 8'h02;
    localparam logic [7:0] ADDR_CAUSE        = 8'h03;
    localparam logic [7:0] ADDR_PREV_LEVEL   = 8'h04;
    localparam logic [7:0] ADDR_CUR_LEVEL    = 8'h05;
    localparam logic [7:0] ADDR_CONTROL      = 8'h06;
    localparam logic [7:0] ADDR_EXECUTE      = 8'h07;
    localparam logic [7:0] ADDR_SET_REQUEST  = 8'h08;
    localparam logic [7:0] ADDR_SET_ENABLE   = 8'h09;
    localparam logic [7:0] ADDR_CLR_REQUEST  = 8'h0c;
    localparam logic [7:0] ADDR_CLR_ENABLE   = 8'h0d;
    localparam logic [3:0] SAVED_PC_PAGE     = 4'h1;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int CTRL_ON_BIT      = 0;
    localparam int CTRL_OFF_BIT     = 1;
    localparam int CTRL_GIVE_UP_BIT = 2;
    localparam int SRC_PROTECT_BIT  = 2;
    localparam int SRC_PAGE_BIT     = 3;
    localparam int SRC_POWER_BIT    = 10;

    // ************************************************************
    // Codes and reset values.
    // ************************************************************
    localparam logic [3:0]  INTERNAL_LEVEL   = 4'he;
    localparam logic [3:0]  IDLE_LEVEL       = 4'h0;
    localparam logic [8:0]  IRR_OPCODE       = 9'h0a1;
    localparam logic [2:0]  DP_CODE          = 3'h2;
    localparam logic [15:0] MASK_RESET       = 16'h0000;
    localparam logic [15:0] PC_RESET         = 16'h0000;
    localparam logic [3:0]  CAUSE_RESET      = 4'h0;

    // ************************************************************
    // Carrier types.
    // ************************************************************
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } plic_bus_req_t;

    typedef struct packed {
        logic [15:0] pc_now;
        logic [15:0] pc_next;
        logic        fetch_cycle;
    } plic_cpu_stat_t;

endpackage : plic_pkg

//--- hw/plic_core.sv
// Program level interrupt control: level masks, internal cause code, on/off and give-up.
// Assumes one 100 MHz clock, a register port driven by the processor on that clock,
// and internal event pulses produced by logic on the same clock.
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps

module plic_core #(
    parameter int SOURCES = 16
) (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire plic_pkg::plic_bus_req_t bus_req,
    input  wire logic                    privileged_mode,
    input  wire logic [SOURCES-1:0]      internal_event,
    input  wire plic_pkg::plic_cpu_stat_t cpu_stat,
    output logic [15:0]                  read_data,
    output logic [3:0]                   current_level,
    output logic [3:0]                   previous_level,
    output logic                         interrupt_lamp,
    output logic                         level_switch,
    output logic [15:0]                  resume_pc,
    output logic                         privilege_fault
);

    // ************************************************************
    // Highest set bit of a mask.
    // ************************************************************
    function automatic logic [4:0] plic_highest(input logic [15:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (v[i]) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction : plic_highest

    // ************************************************************
    // State.
    // ************************************************************
    logic [15:0] level_request_mask;
    logic [15:0] level_enable_mask;
    logic [15:0] internal_source_enable;
    logic [15:0] internal_detect;
    logic [3:0]  internal_cause_code;
    logic        cause_locked;
    logic        interrupts_on;
    logic        fetch_violation;
    logic [15:0] exr_result;
    logic [15:0] saved_pc [16];

    // ************************************************************
    // Access decode.
    // ************************************************************
    wire         wr_ok       = bus_req.wr & privileged_mode;
    wire         rd_ok       = bus_req.rd & privileged_mode;
    wire         refused     = (bus_req.wr | bus_req.rd) & ~privileged_mode;
    wire  [7:0]  addr        = bus_req.addr;
    wire  [15:0] acc         = bus_req.wdata;
    wire         pc_page     = (addr[7:4] == plic_pkg::SAVED_PC_PAGE);
    wire  [3:0]  pc_index    = addr[3:0];

    wire         wr_request  = wr_ok & (addr == plic_pkg::ADDR_REQUEST);
    wire         wr_enable   = wr_ok & (addr == plic_pkg::ADDR_ENABLE);
    wire         wr_source   = wr_ok & (addr == plic_pkg::ADDR_SOURCE_EN);
    wire         wr_control  = wr_ok & (addr == plic_pkg::ADDR_CONTROL);
    wire         wr_execute  = wr_ok & (addr == plic_pkg::ADDR_EXECUTE);
    wire         set_request = wr_ok & (addr == plic_pkg::ADDR_SET_REQUEST);
    wire         set_enable  = wr_ok & (addr == plic_pkg::ADDR_SET_ENABLE);
    wire         clr_request = wr_ok & (addr == plic_pkg::ADDR_CLR_REQUEST);
    wire         clr_enable  = wr_ok & (addr == plic_pkg::ADDR_CLR_ENABLE);
    wire         wr_saved_pc = wr_ok & pc_page;
    wire         rd_cause    = rd_ok & (addr == plic_pkg::ADDR_CAUSE);

    wire         on_cmd      = wr_control & acc[plic_pkg::CTRL_ON_BIT];
    wire         off_cmd     = wr_control & acc[plic_pkg::CTRL_OFF_BIT];
    wire         give_up_cmd = wr_control & acc[plic_pkg::CTRL_GIVE_UP_BIT] & ~off_cmd;

    // ************************************************************
    // Internal interrupt capture.
    // ************************************************************
    wire  [15:0] source_pending = internal_detect & internal_source_enable;
    wire  [4:0]  source_top     = plic_highest(source_pending);
    wire         power_pending  = source_pending[plic_pkg::SRC_POWER_BIT];
    wire  [3:0]  next_cause     = power_pending ? 4'(plic_pkg::SRC_POWER_BIT)
                                                : source_top[3:0];
    wire         capture        = ~cause_locked & source_top[4];
    wire  [15:0] capture_bit    = capture ? (16'h0001 << next_cause) : 16'h0000;
    wire  [15:0] event_bits     = 16'(internal_event);
    wire  [15:0] next_detect    = (internal_detect & ~capture_bit) | event_bits;

    wire  [3:0]  next_cause_code = capture  ? next_cause
                                 : rd_cause ? plic_pkg::CAUSE_RESET
                                 : internal_cause_code;
    wire         next_locked     = capture ? 1'b1 : (rd_cause ? 1'b0 : cause_locked);

    wire         violation_now   = (event_bits[plic_pkg::SRC_PROTECT_BIT]
                                 | event_bits[plic_pkg::SRC_PAGE_BIT]) & cpu_stat.fetch_cycle;

    // ************************************************************
    // Mask updates.
    // ************************************************************
    wire  [15:0] own_bit     = 16'h0001 << current_level;
    wire  [15:0] internal_rq = capture ? (16'h0001 << plic_pkg::INTERNAL_LEVEL)
                                       : 16'h0000;

    wire  [15:0] sw_request  = wr_request  ? acc
                             : set_request ? (level_request_mask | acc)
                             : clr_request ? (level_request_mask & ~acc)
                             : level_request_mask;

    wire  [15:0] given_up    = give_up_cmd ? (sw_request & ~own_bit) : sw_request;
    wire  [15:0] next_request = given_up | internal_rq;

    wire  [15:0] next_enable = wr_enable  ? acc
                             : set_enable ? (level_enable_mask | acc)
                             : clr_enable ? (level_enable_mask & ~acc)
                             : level_enable_mask;

    wire  [15:0] next_source = wr_source ? acc : internal_source_enable;

    // ************************************************************
    // Level selection.
    // ************************************************************
    wire  [15:0] active       = next_request & next_enable;
    wire  [4:0]  active_top   = plic_highest(active);
    wire         next_on      = (interrupts_on | on_cmd) & ~off_cmd;
    wire         raise        = next_on & active_top[4]
                              & (active_top[3:0] > current_level) & ~give_up_cmd;
    wire         drop         = next_on & give_up_cmd;
    wire         do_switch    = raise | drop;
    wire  [3:0]  target_level = active_top[4] ? active_top[3:0]
                                              : plic_pkg::IDLE_LEVEL;
    wire         keep_pc      = fetch_violation | violation_now;
    wire  [15:0] leave_pc     = keep_pc ? cpu_stat.pc_now : cpu_stat.pc_next;

    // ************************************************************
    // Execute-register and read selection.
    // ************************************************************
    wire         is_irr      = (acc[15:7] == plic_pkg::IRR_OPCODE)
                             & (acc[2:0] == plic_pkg::DP_CODE);
    wire  [15:0] irr_value   = is_irr ? saved_pc[acc[6:3]] : 16'h0000;

    wire  [15:0] prev_word   = {plic_pkg::IRR_OPCODE, previous_level,
                                plic_pkg::DP_CODE};
    wire  [15:0] cause_word  = {12'h000, internal_cause_code};

    wire  [15:0] read_mux    =
        (addr == plic_pkg::ADDR_REQUEST)    ? level_request_mask
      : (addr == plic_pkg::ADDR_ENABLE)     ? level_enable_mask
      : (addr == plic_pkg::ADDR_SOURCE_EN)  ? internal_source_enable
      : (addr == plic_pkg::ADDR_CAUSE)      ? cause_word
      : (addr == plic_pkg::ADDR_PREV_LEVEL) ? prev_word
      : (addr == plic_pkg::ADDR_CUR_LEVEL)  ? {12'h000, current_level}
      : (addr == plic_pkg::ADDR_CONTROL)    ? {15'h0000, interrupts_on}
      : (addr == plic_pkg::ADDR_EXECUTE)    ? exr_result
      : pc_page                             ? saved_pc[pc_index]
      : 16'h0000;

    // ************************************************************
    // Masks and cause code.
    // ************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            level_request_mask     <= plic_pkg::MASK_RESET;
            level_enable_mask      <= plic_pkg::MASK_RESET;
            internal_source_enable <= plic_pkg::MASK_RESET;
            internal_detect        <= plic_pkg::MASK_RESET;
            internal_cause_code    <= plic_pkg::CAUSE_RESET;
            cause_locked           <= 1'b0;
        end else begin
            level_request_mask     <= next_request;
            level_enable_mask      <= next_enable;
            internal_source_enable <= next_source;
            internal_detect        <= next_detect;
            internal_cause_code    <= next_cause_code;
            cause_locked           <= next_locked;
        end
    end

    // ************************************************************
    // Interrupt system on and off.
    // ************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            interrupts_on  <= 1'b0;
            interrupt_lamp <= 1'b0;
        end else begin
            interrupts_on  <= next_on;
            interrupt_lamp <= next_on;
        end
    end

    // ************************************************************
    // Level switching.
    // ************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            current_level  <= plic_pkg::IDLE_LEVEL;
            previous_level <= plic_pkg::IDLE_LEVEL;
            level_switch   <= 1'b0;
            resume_pc      <= plic_pkg::PC_RESET;
        end else begin
            level_switch <= do_switch;
            if (do_switch) begin
                previous_level <= current_level;
                current_level  <= target_level;
                resume_pc      <= saved_pc[target_level];
            end
        end
    end

    // ************************************************************
    // Fetch violation hold.
    // ************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fetch_violation <= 1'b0;
        end else if (do_switch) begin
            fetch_violation <= 1'b0;
        end else if (violation_now) begin
            fetch_violation <= 1'b1;
        end
    end

    // ************************************************************
    // Saved program counters.
    // ************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 16; i++) begin
                saved_pc[i] <= plic_pkg::PC_RESET;
            end
        end else begin
            if (wr_saved_pc) begin
                saved_pc[pc_index] <= acc;
            end
            if (do_switch) begin
                saved_pc[current_level] <= leave_pc;
            end
        end
    end

    // ************************************************************
    // Execute register result.
    // ************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            exr_result <= 16'h0000;
        end else if (wr_execute) begin
            exr_result <= irr_value;
        end
    end

    // ************************************************************
    // Read data and refusal.
    // ************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            read_data       <= 16'h0000;
            privilege_fault <= 1'b0;
        end else begin
            read_data       <= rd_ok ? read_mux : 16'h0000;
            privilege_fault <= refused;
        end
    end

endmodule : plic_core

//--- test/plic_core_checker.sv
// Concurrent checks on the ports of plic_core, bound into every instance.
// Assumes plic_pkg is compiled first and one clock with an async high reset.
`timescale 1ns/10ps
module plic_core_checker #(
    parameter int SOURCES = 16
) (
    input wire logic                     clk,
    input wire logic                     reset,
    input wire plic_pkg::plic_bus_req_t  bus_req,
    input wire logic                     privileged_mode,
    input wire logic [SOURCES-1:0]       internal_event,
    input wire plic_pkg::plic_cpu_stat_t cpu_stat,
    input wire logic [15:0]              read_data,
    input wire logic [3:0]               current_level,
    input wire logic [3:0]               previous_level,
    input wire logic                     interrupt_lamp,
    input wire logic                     level_switch,
    input wire logic [15:0]              resume_pc,
    input wire logic                     privilege_fault
);
    wire logic take_rd;
    wire logic ctrl_wr;
    assign take_rd = bus_req.rd & privileged_mode;
    assign ctrl_wr = bus_req.wr & privileged_mode & (bus_req.addr == plic_pkg::ADDR_CONTROL);

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_on_write;
        ctrl_wr && bus_req.wdata[0] && !bus_req.wdata[1];
    endsequence
    sequence s_off_write;
        ctrl_wr && bus_req.wdata[1] && !bus_req.wdata[0];
    endsequence
    sequence s_refused;
        (bus_req.wr || bus_req.rd) && !privileged_mode;
    endsequence
    sequence s_give_up;
        ctrl_wr && bus_req.wdata[2] && !bus_req.wdata[1] && interrupt_lamp && current_level != 0;
    endsequence

    a_refused_fault: assert property (s_refused |=> privilege_fault)
        else $error("refused strobe without fault pulse");
    a_refused_quiet: assert property (bus_req.rd && !privileged_mode |=> read_data == 16'h0000)
        else $error("refused read returned data");
    a_lamp_lights: assert property (s_on_write |=> interrupt_lamp)
        else $error("lamp dark after on");
    a_lamp_darkens: assert property (s_off_write |=> !interrupt_lamp)
        else $error("lamp lit after off");
    a_off_holds_level: assert property (!interrupt_lamp && !(ctrl_wr && bus_req.wdata[0])
        |=> $stable(current_level))
        else $error("level moved while system off");
    a_switch_pulse: assert property ($changed(current_level) |-> level_switch)
        else $error("level change without switch pulse");
    a_prev_format: assert property (take_rd && bus_req.addr == plic_pkg::ADDR_PREV_LEVEL
        |=> read_data == {plic_pkg::IRR_OPCODE, $past(previous_level), plic_pkg::DP_CODE})
        else $error("previous level readout malformed");
    a_cause_upper: assert property (take_rd && bus_req.addr == plic_pkg::ADDR_CAUSE
        |=> read_data[15:4] == 12'h000)
        else $error("cause readout upper bits set");
    a_read_idle: assert property (!bus_req.rd |=> read_data == 16'h0000)
        else $error("read data without read");
    a_give_up_leaves: assert property (s_give_up |=> (current_level != $past(current_level))
        && previous_level == $past(current_level) && level_switch)
        else $error("give up did not leave level");
endmodule : plic_core_checker

bind plic_core plic_core_checker #(.SOURCES(SOURCES)) u_chk (.clk(clk), .reset(reset),
    .bus_req(bus_req), .privileged_mode(privileged_mode), .internal_event(internal_event),
    .cpu_stat(cpu_stat), .read_data(read_data), .current_level(current_level),
    .previous_level(previous_level), .interrupt_lamp(interrupt_lamp),
    .level_switch(level_switch), .resume_pc(resume_pc), .privilege_fault(privilege_fault));

//--- test/plic_core_tb.sv
// Self-checking bench for plic_core; resume_pc is checked directly, level_switch, privilege_fault and interrupt_lamp
// only by the checker, the rest over the register port.
// Assumes plic_pkg, plic_core and the checker are compiled first.
`timescale 1ns/10ps
module plic_core_tb;
    logic                     clk;
    logic                     reset;
    plic_pkg::plic_bus_req_t  bus_req;
    logic                     privileged_mode;
    logic [15:0]              internal_event;
    plic_pkg::plic_cpu_stat_t cpu_stat;
    logic [15:0]              read_data;
    logic [3:0]               current_level;
    logic [3:0]               previous_level;
    logic                     interrupt_lamp;
    logic                     level_switch;
    logic [15:0]              resume_pc;
    logic                     privilege_fault;
    logic [15:0]              exp_q[$];
    logic                     rd_q;
    int                       num_errors;
    int                       n_checks;
    logic [15:0]              m;
    logic [15:0]              s;
    logic [15:0]              c;
    logic [15:0]              prev_cmd;

    plic_core #(.SOURCES(16)) uut (.clk(clk), .reset(reset), .bus_req(bus_req),
        .privileged_mode(privileged_mode), .internal_event(internal_event),
        .cpu_stat(cpu_stat), .read_data(read_data), .current_level(current_level),
        .previous_level(previous_level), .interrupt_lamp(interrupt_lamp),
        .level_switch(level_switch), .resume_pc(resume_pc), .privilege_fault(privilege_fault));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t read %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic op(input logic [7:0] a, input logic [15:0] d, input logic w, input logic r,
                      input logic p = 1'b1, input logic [15:0] e = 16'h0000);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
        privileged_mode <= p;
        internal_event <= e;
    endtask : op

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic p = 1'b1);
        op(a, d, 1'b1, 1'b0, p);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic p = 1'b1);
        exp_q.push_back(e);
        op(a, 16'h0000, 1'b0, 1'b1, p);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) op(8'h00, 16'h0000, 1'b0, 1'b0);
    endtask : idle

    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    // ****************************************
    // Monitor: compares each read answer with the oldest note.
    // ****************************************
    always @(posedge clk) begin
        if (rd_q === 1'b1) begin
            check(read_data, exp_q.pop_front());
        end
        rd_q <= bus_req.rd;
    end

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        final_report();
    end

    // ****************************************
    // Main sequence.
    // ****************************************
    initial begin
        void'($urandom(32'hf3cb));
        reset = 1'b1;
        bus_req = '0;
        privileged_mode = 1'b1;
        internal_event = 16'h0000;
        cpu_stat = '0;
        num_errors = 0;
        n_checks = 0;
        prev_cmd = {plic_pkg::IRR_OPCODE, 4'h0, plic_pkg::DP_CODE};
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        rd(plic_pkg::ADDR_ENABLE, 16'h0000);
        rd(plic_pkg::ADDR_CUR_LEVEL, 16'h0000);
        for (int t = 0; t < 2; t++) begin
            for (int i = 0; i < 4; i++) begin
                m = $urandom();
                s = $urandom();
                c = $urandom();
                wr(plic_pkg::ADDR_REQUEST + 8'(t), m);
                rd(plic_pkg::ADDR_REQUEST + 8'(t), m);
                wr(plic_pkg::ADDR_SET_REQUEST + 8'(t), s);
                wr(plic_pkg::ADDR_CLR_REQUEST + 8'(t), c);
                rd(plic_pkg::ADDR_REQUEST + 8'(t), (m | s) & ~c);
            end
            wr(plic_pkg::ADDR_REQUEST + 8'(t), 16'h0000);
        end
        wr(plic_pkg::ADDR_SOURCE_EN, 16'h040c);
        rd(plic_pkg::ADDR_SOURCE_EN, 16'h040c);
        op(8'h00, 16'h0000, 1'b0, 1'b0, 1'b1, 16'h040c);
        idle(2);
        rd(plic_pkg::ADDR_CAUSE, 16'h000a);
        rd(plic_pkg::ADDR_REQUEST, 16'h4000);
        idle(2);
        rd(plic_pkg::ADDR_CAUSE, 16'h0003);
        idle(2);
        rd(plic_pkg::ADDR_CAUSE, 16'h0002);
        idle(2);
        rd(plic_pkg::ADDR_CAUSE, 16'h0000);
        m = $urandom();
        cpu_stat <= '{pc_now: 16'h0000, pc_next: m, fetch_cycle: 1'b0};
        wr(plic_pkg::ADDR_ENABLE, 16'h4220);
        wr(plic_pkg::ADDR_CONTROL, 16'h0001);
        idle(2);
        rd(plic_pkg::ADDR_CUR_LEVEL, 16'h000e);
        rd(plic_pkg::ADDR_CONTROL, 16'h0001);
        rd({plic_pkg::SAVED_PC_PAGE, 4'h0}, m);
        rd(plic_pkg::ADDR_PREV_LEVEL, prev_cmd);
        wr(plic_pkg::ADDR_EXECUTE, prev_cmd);
        rd(plic_pkg::ADDR_EXECUTE, m);
        s = $urandom();
        cpu_stat <= '{pc_now: 16'h0000, pc_next: s, fetch_cycle: 1'b0};
        wr(plic_pkg::ADDR_SET_REQUEST, 16'h0020);
        wr(plic_pkg::ADDR_CONTROL, 16'h0004);
        idle(2);
        rd(plic_pkg::ADDR_CUR_LEVEL, 16'h0005);
        rd(plic_pkg::ADDR_REQUEST, 16'h0020);
        rd({plic_pkg::SAVED_PC_PAGE, 4'he}, s);
        wr(plic_pkg::ADDR_CONTROL, 16'h0004);
        idle(2);
        rd(plic_pkg::ADDR_CUR_LEVEL, 16'h0000);
        check(resume_pc, m);
        wr(plic_pkg::ADDR_CONTROL, 16'h0002);
        wr(plic_pkg::ADDR_SET_REQUEST, 16'h0220);
        idle(2);
        rd(plic_pkg::ADDR_CUR_LEVEL, 16'h0000);
        rd(plic_pkg::ADDR_CONTROL, 16'h0000);
        wr(plic_pkg::ADDR_CONTROL, 16'h0001);
        idle(2);
        rd(plic_pkg::ADDR_CUR_LEVEL, 16'h0009);
        for (int f = 1; f >= 0; f--) begin
            m = $urandom();
            s = $urandom();
            cpu_stat <= '{pc_now: m, pc_next: s, fetch_cycle: f[0]};
            op(8'h00, 16'h0000, 1'b0, 1'b0, 1'b1, 16'h0004);
            idle(3);
            rd(plic_pkg::ADDR_CUR_LEVEL, 16'h000e);
            rd({plic_pkg::SAVED_PC_PAGE, 4'h9}, f ? m : s);
            rd(plic_pkg::ADDR_CAUSE, 16'h0002);
            wr(plic_pkg::ADDR_CONTROL, 16'h0004);
            idle(2);
            rd(plic_pkg::ADDR_CUR_LEVEL, 16'h0009);
        end
        wr(plic_pkg::ADDR_ENABLE, 16'hffff, 1'b0);
        rd(plic_pkg::ADDR_ENABLE, 16'h0000, 1'b0);
        wr(plic_pkg::ADDR_CONTROL, 16'h0002, 1'b0);
        rd(plic_pkg::ADDR_ENABLE, 16'h4220);
        rd(plic_pkg::ADDR_CONTROL, 16'h0001);
        rd(8'h20, 16'h0000);
        idle(3);
        final_report();
    end
endmodule : plic_core_tb
